// ### core/sarp_port.sv
`timescale 1ns/100ps
`include "sarp_cfg.svh"
module sarp_port #(
   parameter int RES_W = `SARP_RES_W,
   parameter int DEPTH = `SARP_FIFO_DEPTH
) (
   input  wire logic             CLK_I,        // 250 MHz clock
   input  wire logic             RST_N_I,      // sync reset, active low
   input  wire logic             SEL_N_I,      // host select, active low
   input  wire logic             SCLK_I,       // host serial clock
   input  wire logic             SMP_VALID_I,  // sampled code valid
   output logic                  SMP_READY_O,  // sample buffer not full
   input  wire logic [RES_W-1:0] SMP_DATA_I,   // unsigned sampled code
   output logic                  SER_OUT_O,    // serial_result_out level
   output logic                  SER_OE_O,     // serial_result_out enable
   output logic                  BUSY_O        // frame in progress
);
   localparam int FRAME_W = `SARP_FRAME_BITS;
   localparam int LEAD_W  = `SARP_LEAD_ZEROS;
   localparam int CNT_W   = `SARP_CNT_W;

   logic [2:0]            sel_sync_r;
   logic [2:0]            sclk_sync_r;
   logic                  sel_fall;
   logic                  sel_high;
   logic                  sclk_fall;
   logic                  frame_start;
   logic                  shift_step;
   logic                  last_fall;
   sarp_pkg::sarp_state_t state_r;
   sarp_pkg::sarp_state_t state_nxt;
   logic [CNT_W-1:0]      bit_cnt_r;
   logic [CNT_W-1:0]      bit_cnt_nxt;
   logic [FRAME_W-1:0]    shift_r;
   logic [FRAME_W-1:0]    shift_nxt;
   logic                  ser_out_r;
   logic                  ser_out_nxt;
   logic                  ser_oe_r;
   logic                  ser_oe_nxt;
   logic                  fifo_valid;
   logic                  fifo_take;
   logic [RES_W-1:0]      fifo_data;

   // falling edge from the two oldest synchroniser stages
   function automatic logic fall_of(input logic [2:0] s);
      fall_of = s[2] & ~s[1];
   endfunction

   // result word as it leaves the port: lead zeros, then the code
   function automatic logic [FRAME_W-1:0] frame_of(
      input logic [RES_W-1:0] code
   );
      frame_of = FRAME_W'({{LEAD_W{1'b0}}, code});
   endfunction

   // first stage feeds only the second; edges use stages two and three
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         sel_sync_r <= 3'h7;
      end else begin
         sel_sync_r <= {sel_sync_r[1:0], SEL_N_I};
      end
   end

   // serial clock parks high, so resetting high avoids a false edge
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         sclk_sync_r <= 3'h7;
      end else begin
         sclk_sync_r <= {sclk_sync_r[1:0], SCLK_I};
      end
   end

   assign sel_fall    = fall_of(sel_sync_r);
   assign sel_high    = sel_sync_r[1];
   assign sclk_fall   = fall_of(sclk_sync_r);
   assign frame_start = (state_r == sarp_pkg::SARP_IDLE) & sel_fall;
   assign shift_step  = (state_r == sarp_pkg::SARP_SHIFT) & sclk_fall;
   assign last_fall   = (bit_cnt_r == CNT_W'(FRAME_W));

   // buffer absorbs codes arriving while a frame is still shifting
   sarp_fifo #(
      .WIDTH (RES_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk_i       (CLK_I),
      .rst_n_i     (RST_N_I),
      .in_valid_i  (SMP_VALID_I),
      .in_ready_o  (SMP_READY_O),
      .in_data_i   (SMP_DATA_I),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_take),
      .out_data_o  (fifo_data)
   );

   assign fifo_take = frame_start & fifo_valid;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         sarp_pkg::SARP_IDLE: begin
            if (sel_fall) begin
               state_nxt = sarp_pkg::SARP_SHIFT;
            end
         end
         sarp_pkg::SARP_SHIFT: begin
            if (sel_high) begin
               state_nxt = sarp_pkg::SARP_IDLE;
            end else if (shift_step && last_fall) begin
               state_nxt = sarp_pkg::SARP_DONE;
            end
         end
         sarp_pkg::SARP_DONE: begin
            if (sel_high) begin
               state_nxt = sarp_pkg::SARP_IDLE;
            end
         end
         default: begin
            state_nxt = sarp_pkg::SARP_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         state_r <= sarp_pkg::SARP_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // bit counter steps only on host clock edges; no clock, no progress
   always_comb begin
      bit_cnt_nxt = bit_cnt_r;
      if (frame_start) begin
         bit_cnt_nxt = '0;
      end else if (shift_step && !last_fall) begin
         bit_cnt_nxt = bit_cnt_r + 1'b1;
      end
   end

   always_comb begin
      shift_nxt = shift_r;
      if (frame_start) begin
         // underflow sends zero code rather than a stale one
         shift_nxt = frame_of(fifo_valid ? fifo_data : '0);
      end else if (shift_step) begin
         shift_nxt = {shift_r[FRAME_W-2:0], 1'b0};
      end
   end

   always_comb begin
      ser_oe_nxt = ser_oe_r;
      if (sel_high) begin
         ser_oe_nxt = 1'b0;
      end else if (frame_start) begin
         ser_oe_nxt = 1'b1;
      end else if (shift_step && last_fall) begin
         ser_oe_nxt = 1'b0;
      end
   end

   // line parks low on deselect; after the last fall the released wire keeps the final bit
   always_comb begin
      ser_out_nxt = ser_out_r;
      if (sel_high) begin
         ser_out_nxt = 1'b0;
      end else if (frame_start) begin
         ser_out_nxt = 1'b0;
      end else if (shift_step && !last_fall) begin
         ser_out_nxt = shift_r[FRAME_W-1];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         bit_cnt_r <= '0;
      end else begin
         bit_cnt_r <= bit_cnt_nxt;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         shift_r <= '0;
      end else begin
         shift_r <= shift_nxt;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         ser_oe_r <= 1'b0;
      end else begin
         ser_oe_r <= ser_oe_nxt;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         ser_out_r <= 1'b0;
      end else begin
         ser_out_r <= ser_out_nxt;
      end
   end

   assign SER_OUT_O = ser_out_r;
   assign SER_OE_O  = ser_oe_r;
   assign BUSY_O    = (state_r == sarp_pkg::SARP_SHIFT);
endmodule

// ### common/sarp_cfg.svh
`ifndef SARP_CFG_SVH
`define SARP_CFG_SVH
`define SARP_RES_W      12
`define SARP_LEAD_ZEROS 4
`define SARP_FRAME_BITS 16
`define SARP_FIFO_DEPTH 8
`define SARP_CNT_W      5
`endif

// ### common/sarp_pkg.sv
package sarp_pkg;
   typedef enum logic [1:0] {
      SARP_IDLE  = 2'b00,
      SARP_SHIFT = 2'b01,
      SARP_DONE  = 2'b10
   } sarp_state_t;
endpackage

// ### core/sarp_fifo.sv
`timescale 1ns/100ps
module sarp_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,     // clock
   input  wire logic             rst_n_i,   // sync reset, active low
   input  wire logic             in_valid_i,// write request
   output logic                  in_ready_o,// not full
   input  wire logic [WIDTH-1:0] in_data_i, // write data
   output logic                  out_valid_o,// not empty
   input  wire logic             out_ready_i,// read accept
   output logic      [WIDTH-1:0] out_data_o // head word
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [AW:0]      cnt_r;
   logic             wr_en;
   logic             rd_en;

   function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
      inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_r != '0);
   assign wr_en       = in_valid_i & in_ready_o;
   assign rd_en       = out_valid_o & out_ready_i;
   assign out_data_o  = mem_r[rd_r];

   always_ff @(posedge clk_i) begin
      if (wr_en) begin
         mem_r[wr_r] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (wr_en) begin
            wr_r <= inc(wr_r);
         end
         if (rd_en) begin
            rd_r <= inc(rd_r);
         end
         if (wr_en && !rd_en) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (rd_en && !wr_en) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule

// ### bench/sarp_host.sv
`timescale 1ns/100ps
module sarp_host (
   input  wire logic        go_i,    // run frames
   input  wire logic        line_i,  // data wire
   output logic             sel_n_o, // select
   output logic             sclk_o,  // serial clock
   output logic [15:0]      word_o,  // captured word
   output logic             got_o    // toggles per word
);
   initial begin
      sel_n_o = 1'b1;
      sclk_o = 1'b1; // parked high outside frames
      word_o = 16'h0000;
      got_o = 1'b0;
      forever begin
         wait (go_i);
         #100.3 sel_n_o = 1'b0;
         #80;
         repeat (16) begin
            sclk_o = 1'b0;
            #80 sclk_o = 1'b1;
            word_o = {word_o[14:0], line_i};
            #80;
         end
         sclk_o = 1'b0;
         #80 sel_n_o = 1'b1;
         sclk_o = 1'b1;
         got_o = ~got_o;
      end
   end
endmodule

// ### bench/sarp_port_checker.sv
`timescale 1ns/100ps
module sarp_port_checker (
   input wire logic CLK_I,     // clock
   input wire logic RST_N_I,   // reset
   input wire logic SEL_N_I,   // select
   input wire logic SCLK_I,    // serial clock
   input wire logic SER_OUT_O, // data
   input wire logic SER_OE_O,  // enable
   input wire logic BUSY_O     // busy
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   property p_idle; SEL_N_I[*6] |-> !SER_OE_O; endproperty
   a_idle: assert property (p_idle) else $error("oe while idle");
   property p_start; $fell(SEL_N_I) |-> ##[2:6] SER_OE_O; endproperty
   a_start: assert property (p_start) else $error("no start");
   property p_lead; $rose(SER_OE_O) |-> ##2 (!SER_OUT_O)[*8]; endproperty
   a_lead: assert property (p_lead) else $error("lead bit");
   property p_shift; SER_OE_O && $past(SER_OE_O, 2) && $changed(SER_OUT_O)
      |-> !$past(SCLK_I, 2); endproperty
   a_shift: assert property (p_shift) else $error("bad change");
   property p_rel; $fell(SER_OE_O) && !SEL_N_I |-> !$past(SCLK_I, 2);
   endproperty
   a_rel: assert property (p_rel) else $error("bad release");
   property p_drv; $rose(SER_OE_O) |-> !$past(SEL_N_I, 2); endproperty
   a_drv: assert property (p_drv) else $error("bad drive");
   property p_frame; SEL_N_I[*6] |-> !BUSY_O; endproperty
   a_frame: assert property (p_frame) else $error("busy idle");
   property p_hold; $stable(SCLK_I)[*7] ##0 (SER_OE_O && $past(SER_OE_O, 2))
      |-> $stable(SER_OUT_O); endproperty
   a_hold: assert property (p_hold) else $error("no edge");
endmodule
bind sarp_port sarp_port_checker u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
   .SEL_N_I(SEL_N_I), .SCLK_I(SCLK_I), .SER_OUT_O(SER_OUT_O),
   .SER_OE_O(SER_OE_O), .BUSY_O(BUSY_O));

// ### bench/sarp_port_tb.sv
`timescale 1ns/100ps
module sarp_port_tb;
   logic        clk, rst_n, vld, go, sel_n, sclk, rdy, sout, soe, busy;
   logic        lst, got;
   logic [11:0] dat;
   logic [15:0] word;
   logic [15:0] exp_q[$];
   int          failures, total_checks, seed;
   wire         line = soe ? sout : ~lst; // released line shows inverse
   sarp_port dut (.CLK_I(clk), .RST_N_I(rst_n), .SEL_N_I(sel_n),
      .SCLK_I(sclk), .SMP_VALID_I(vld), .SMP_READY_O(rdy), .SMP_DATA_I(dat),
      .SER_OUT_O(sout), .SER_OE_O(soe), .BUSY_O(busy));
   sarp_host host (.go_i(go), .line_i(line), .sel_n_o(sel_n),
      .sclk_o(sclk), .word_o(word), .got_o(got));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (soe) lst <= sout;
   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      total_checks++;
      if (s !== e) begin
         $display("unexpected %s expected %h seen %h", n, e, s);
         failures++;
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(got) if (exp_q.size() > 0) chk("frame", exp_q.pop_front(), word);
   initial begin
      #60000 failures++;
      close_out();
   end
   initial begin
      seed = 32'h0dfc2b99;
      {rst_n, vld, go, lst, dat} = '0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         #1 vld = 1'b1;
         dat = i == 0 ? 12'h000 : i == 1 ? 12'hfff : 12'($random(seed));
         if (i < 8) exp_q.push_back({4'h0, dat});
         @(posedge clk);
      end
      #1 vld = 1'b0;
      chk("ready", 16'h0000, {15'h0000, rdy});
      exp_q.push_back(16'h0000); // empty buffer sends zero code
      go = 1'b1;
      repeat (8) @(got);
      go = 1'b0;
      @(got);
      #400;
      $display("fill and drain test done");
      close_out();
   end
endmodule
